// file: rtl/rssa_pkg.sv
package rssa_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_FEATURE       = 8'h12;
	localparam logic [7:0]  IDX_SHED_TIMEOUT  = 8'h1b;
	localparam logic [7:0]  IDX_SAFE_FLAG     = 8'h1c;
	localparam logic [7:0]  IDX_SAFE_SET      = 8'h1d;
	localparam logic [7:0]  IDX_SAFE_CLEAR    = 8'h1e;
	localparam logic [7:0]  IDX_ALERT_MAX     = 8'h1f;
	localparam logic [7:0]  IDX_ALERT_LIMIT   = 8'h20;
	localparam logic [7:0]  IDX_RETRY         = 8'h21;
	localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h22;
	localparam logic [7:0]  IDX_IRQ_ENABLE    = 8'h23;
	localparam logic [7:0]  IDX_IRQ_CLEAR     = 8'h24;
	localparam logic [7:0]  IDX_SHED_POLICY   = 8'h25;
	localparam logic [7:0]  IDX_BLOCK_STATE   = 8'h26;
	localparam int          PADDR_W           = 12;

	// Field positions
	localparam int          FEAT_SAFE_BIT     = 3;
	localparam int          BST_INFL_LSB      = 0;
	localparam int          BST_LO_LSB        = 8;
	localparam int          BST_SHED_LSB      = 16;
	localparam int          IRQ_SHED_BIT      = 0;
	localparam int          IRQ_SAFE_BIT      = 1;
	localparam int          IRQ_RETRY_BIT     = 2;
	localparam int          IRQ_CONFIRM_BIT   = 3;
	localparam int          IRQ_W             = 4;

	// Reset values and encodings
	localparam logic [31:0] SHED_TIMEOUT_RST  = 32'h0009_c400;
	localparam logic [31:0] RETRY_RST         = 32'h0009_c400;
	localparam logic [7:0]  FLAG_CLEAR        = 8'h01;
	localparam logic [7:0]  FLAG_ACTIVE       = 8'h02;
	localparam logic [7:0]  CMD_OFF           = 8'h01;
	localparam logic [7:0]  CMD_GO            = 8'h02;
	localparam logic [7:0]  ALERT_MAX         = 8'h03;
	localparam logic [15:0] FEATURE_RST       = 16'h0000;
	localparam logic [7:0]  SHED_POLICY_RST   = 8'h00;
	localparam int          ALERT_SLOTS       = 3;

	// Timing: one tick is 1/32 ms
	localparam longint      CLK_PERIOD_PS     = 8000;
	localparam longint      TICK_UNIT_PS      = 1000000000 / 32;
	localparam int          TICK_CYCLES_DEF   = int'(TICK_UNIT_PS / CLK_PERIOD_PS);

	typedef struct packed {
		logic       valid;
		logic       resend;
		logic [1:0] slot;
	} rssa_alert_t;
endpackage : rssa_pkg

// file: rtl/rssa_ctl.sv
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
// Contract
// RQ1 - Time remote-output writes in ticks; on timeout shed the block per policy.
// RQ2 - A zero shed timeout never sheds any block.
// RQ3 - Safe-state flag is read-only, 1 clear, 2 active, clear after reset.
// RQ4 - While active, in-service output blocks go to local override.
// RQ5 - Set and clear commands act only when the safe-state feature bit is set.
// RQ6 - Writing 2 to the set command activates the flag; it reads back 1.
// RQ7 - Writing 2 to clear command clears flag; blocks release once fault is gone.
// RQ8 - Writing off to either command changes nothing.
// RQ9 - Fixed maximum of 3 unconfirmed alert reports, never exceeded.
// RQ10 - Writable limit 0 to maximum, reset to maximum, caps reports in flight.
// RQ11 - A zero limit sends no alert reports; the code blocks new reports only and still resends those in flight.
// RQ12 - Resend an unconfirmed report after the retry interval in ticks.
// RQ13 - Reject a limit above maximum or a zero retry interval.
// RQ14 - One 1/32 ms tick from pclk drives both timers.
module rssa_ctl
	import rssa_pkg::*;
#(
	parameter int NUM_OUT     = 2,               // Output blocks served
	parameter int TICK_CYCLES = TICK_CYCLES_DEF  // Clocks per tick
)(
	input  wire logic               pclk,               // Clock, 125 MHz
	input  wire logic               presetn,            // Async reset, low
	input  wire logic               psel,               // APB select
	input  wire logic               penable,            // APB enable
	input  wire logic               pwrite,             // APB direction
	input  wire logic [PADDR_W-1:0] paddr,              // APB byte address
	input  wire logic [31:0]        pwdata,             // APB write data
	output logic      [31:0]        prdata,             // APB read data
	output logic                    pready,             // APB ready
	output logic                    pslverr,            // APB error
	input  wire logic [NUM_OUT-1:0] remote_output_mode_active,        // Block in remote-output mode
	input  wire logic [NUM_OUT-1:0] remote_output_mode_write,         // Host wrote block output
	input  wire logic [NUM_OUT-1:0] block_oos,          // Block out of service
	input  wire logic               field_fault,        // Field fault pin
	output logic      [NUM_OUT-1:0] shed_req,           // Leave remote-output mode
	output logic      [7:0]         shed_policy,        // Shed policy code
	output logic      [NUM_OUT-1:0] local_override,     // Block forced to safe state
	input  wire logic               alert_pending,      // Report waiting to go
	output logic                    alert_taken,        // Pending report accepted
	output rssa_alert_t             alert_out,          // Report send strobe
	input  wire logic               alert_confirm,      // Host confirmed a report
	input  wire logic [1:0]         alert_confirm_slot, // Slot confirmed
	output logic                    irq                 // Interrupt level
);

	generate
		if (NUM_OUT < 1 || NUM_OUT > 8 || TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad
			$error("rssa_ctl: NUM_OUT or TICK_CYCLES out of range");
		end
	endgenerate

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// Tick generator
	logic [15:0]        tick_cnt_reg;
	logic               tick_reg;

	// Field fault synchroniser
	logic               fault_meta_reg;
	logic               fault_sync_reg;

	// Bus side
	logic               pready_reg;
	logic               pslverr_reg;
	logic [31:0]        prdata_reg;
	logic [31:0]        rd_mux;

	// Software registers
	logic [31:0]        shed_timeout_reg;
	logic [7:0]         flag_reg;
	logic [7:0]         limit_reg;
	logic [31:0]        retry_reg;
	logic [15:0]        feature_reg;
	logic [7:0]         policy_reg;
	logic [IRQ_W-1:0]   irq_en_reg;
	logic [IRQ_W-1:0]   irq_stat_reg;
	logic               irq_reg;

	// Alert path
	rssa_alert_t        alert_reg;
	logic               alert_taken_reg;
	logic [ALERT_SLOTS-1:0] busy_vec;
	logic [ALERT_SLOTS-1:0] exp_vec;
	logic [1:0]         infl;
	logic [1:0]         new_slot;
	logic [1:0]         rsd_slot;
	logic               any_free;

	logic [NUM_OUT-1:0] shed_vec;
	logic [NUM_OUT-1:0] shed_ev;
	logic [NUM_OUT-1:0] lo_vec;

	// RQ14 tick divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else begin
			tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 16'h0000 : tick_cnt_reg + 16'h0001;
			tick_reg     <= (tick_cnt_reg == TICK_LAST);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_meta_reg <= 1'b0;
			fault_sync_reg <= 1'b0;
		end else begin
			fault_meta_reg <= field_fault;
			fault_sync_reg <= fault_meta_reg;
		end
	end

	// Address decode
	wire  [7:0] idx       = paddr[9:2];
	wire        acc       = psel & penable;
	wire        hit       = (idx == IDX_FEATURE) || (idx >= IDX_SHED_TIMEOUT && idx <= IDX_BLOCK_STATE);
	wire        addr_ok   = (paddr[1:0] == 2'b00) && (paddr[PADDR_W-1:10] == 2'b00) && hit;
	wire        wr        = acc & pready_reg & pwrite & addr_ok;
	wire        wr_feat   = wr && (idx == IDX_FEATURE);
	wire        wr_shed   = wr && (idx == IDX_SHED_TIMEOUT);
	wire        wr_set    = wr && (idx == IDX_SAFE_SET);
	wire        wr_clr    = wr && (idx == IDX_SAFE_CLEAR);
	wire        wr_limit  = wr && (idx == IDX_ALERT_LIMIT);
	wire        wr_retry  = wr && (idx == IDX_RETRY);
	wire        wr_ien    = wr && (idx == IDX_IRQ_ENABLE);
	wire        wr_iclr   = wr && (idx == IDX_IRQ_CLEAR);
	wire        wr_policy = wr && (idx == IDX_SHED_POLICY);

	// RQ5 feature gate
	wire        safe_ok   = feature_reg[FEAT_SAFE_BIT];
	// RQ6 set command
	wire        set_go    = wr_set & safe_ok & (pwdata[7:0] == CMD_GO);
	// RQ7 clear command
	wire        clr_go    = wr_clr & safe_ok & (pwdata[7:0] == CMD_GO);
	wire        safe_on   = (flag_reg == FLAG_ACTIVE);

	// RQ13 range checks
	wire        limit_ok  = (pwdata[31:8] == 24'h00_0000) && (pwdata[7:0] <= ALERT_MAX);
	wire        retry_ok  = (pwdata != 32'h0000_0000);

	wire [31:0] bst_word  = (32'(infl) << BST_INFL_LSB)
		| (32'(lo_vec) << BST_LO_LSB)
		| (32'(shed_vec) << BST_SHED_LSB);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_ok) begin
			case (idx)
				IDX_FEATURE:      rd_mux = 32'(feature_reg);
				IDX_SHED_TIMEOUT: rd_mux = shed_timeout_reg;
				// RQ3 flag read-only
				IDX_SAFE_FLAG:    rd_mux = 32'(flag_reg);
				// RQ6 momentary reads off
				IDX_SAFE_SET:     rd_mux = 32'(CMD_OFF);
				IDX_SAFE_CLEAR:   rd_mux = 32'(CMD_OFF);
				// RQ9 fixed maximum
				IDX_ALERT_MAX:    rd_mux = 32'(ALERT_MAX);
				IDX_ALERT_LIMIT:  rd_mux = 32'(limit_reg);
				IDX_RETRY:        rd_mux = retry_reg;
				IDX_IRQ_STATUS:   rd_mux = 32'(irq_stat_reg);
				IDX_IRQ_ENABLE:   rd_mux = 32'(irq_en_reg);
				IDX_SHED_POLICY:  rd_mux = 32'(policy_reg);
				IDX_BLOCK_STATE:  rd_mux = bst_word;
				default:          rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// One wait state so that read data and ready both leave flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= acc & ~pready_reg;
			pslverr_reg <= acc & ~pready_reg & ~addr_ok;
			prdata_reg  <= (acc & ~pready_reg & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_reg      <= FEATURE_RST;
			shed_timeout_reg <= SHED_TIMEOUT_RST;
			policy_reg       <= SHED_POLICY_RST;
			irq_en_reg       <= '0;
		end else begin
			if (wr_feat)
				feature_reg <= pwdata[15:0];
			if (wr_shed)
				shed_timeout_reg <= pwdata;
			if (wr_policy)
				policy_reg <= pwdata[7:0];
			if (wr_ien)
				irq_en_reg <= pwdata[IRQ_W-1:0];
		end
	end

	// RQ13 rejected writes keep value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit_reg <= ALERT_MAX;
			retry_reg <= RETRY_RST;
		end else begin
			// RQ10 writable limit
			if (wr_limit && limit_ok)
				limit_reg <= pwdata[7:0];
			if (wr_retry && retry_ok)
				retry_reg <= pwdata;
		end
	end

	// RQ3 flag reset clear
	// RQ8 off writes ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_reg <= FLAG_CLEAR;
		else if (set_go)
			flag_reg <= FLAG_ACTIVE;
		else if (clr_go)
			flag_reg <= FLAG_CLEAR;
	end

	// Per output block: shed timer and safe-state hold
	generate
		for (genvar b = 0; b < NUM_OUT; b++) begin : g_blk
			logic [31:0] cnt_reg;
			logic        shed_reg;
			logic        lo_reg;
			// RQ2 zero never sheds
			wire         armed  = (shed_timeout_reg != 32'h0000_0000);
			wire         expire = remote_output_mode_active[b] & armed & (cnt_reg >= shed_timeout_reg);

			// RQ1 shed timer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg  <= 32'h0000_0000;
					shed_reg <= 1'b0;
				end else begin
					if (!remote_output_mode_active[b] || remote_output_mode_write[b] || !armed)
						cnt_reg <= 32'h0000_0000;
					else if (tick_reg && !expire)
						cnt_reg <= cnt_reg + 32'h0000_0001;
					shed_reg <= remote_output_mode_active[b] & (shed_reg | expire);
				end
			end

			// RQ4 local override
			// RQ7 release after fault
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					lo_reg <= 1'b0;
				else
					lo_reg <= ~block_oos[b] & (safe_on | (lo_reg & fault_sync_reg));
			end

			assign shed_vec[b] = shed_reg;
			assign shed_ev[b]  = expire & ~shed_reg;
			assign lo_vec[b]   = lo_reg;
		end
	endgenerate

	// Alert slot search: lowest free slot, lowest expired slot
	always_comb begin
		infl     = 2'b00;
		new_slot = 2'b00;
		rsd_slot = 2'b00;
		any_free = 1'b0;
		for (int s = ALERT_SLOTS - 1; s >= 0; s--) begin
			infl = infl + 2'(busy_vec[s]);
			if (!busy_vec[s]) begin
				new_slot = 2'(s);
				any_free = 1'b1;
			end
			if (exp_vec[s])
				rsd_slot = 2'(s);
		end
	end

	// RQ12 resend before new
	wire send_rsd = |exp_vec;
	// RQ9 cap at maximum
	// RQ10 cap at limit
	// RQ11 zero limit blocks
	wire send_new = ~send_rsd & alert_pending & ~alert_taken_reg & any_free
		& ({6'b00_0000, infl} < limit_reg);

	generate
		for (genvar s = 0; s < ALERT_SLOTS; s++) begin : g_slot
			logic        busy_reg;
			logic [31:0] cnt_reg;
			wire         conf  = alert_confirm & (alert_confirm_slot == 2'(s)) & busy_reg;
			wire         fresh = send_new & (new_slot == 2'(s));
			wire         again = send_rsd & (rsd_slot == 2'(s));

			// RQ12 confirm timer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					busy_reg <= 1'b0;
					cnt_reg  <= 32'h0000_0000;
				end else begin
					if (conf)
						busy_reg <= 1'b0;
					else if (fresh)
						busy_reg <= 1'b1;
					if (!busy_reg || fresh || again)
						cnt_reg <= 32'h0000_0000;
					else if (tick_reg && cnt_reg < retry_reg)
						cnt_reg <= cnt_reg + 32'h0000_0001;
				end
			end

			assign busy_vec[s] = busy_reg;
			assign exp_vec[s]  = busy_reg & ~conf & (cnt_reg >= retry_reg);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_reg       <= '0;
			alert_taken_reg <= 1'b0;
		end else begin
			alert_reg.valid  <= send_rsd | send_new;
			alert_reg.resend <= send_rsd;
			alert_reg.slot   <= send_rsd ? rsd_slot : new_slot;
			alert_taken_reg  <= send_new;
		end
	end

	// Interrupt events; a new event wins over a clear in the same cycle
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_stat_next;

	always_comb begin
		irq_ev                  = '0;
		irq_ev[IRQ_SHED_BIT]    = |shed_ev;
		irq_ev[IRQ_SAFE_BIT]    = set_go & ~safe_on;
		irq_ev[IRQ_RETRY_BIT]   = send_rsd;
		irq_ev[IRQ_CONFIRM_BIT] = alert_confirm & |busy_vec;
		irq_clr                 = wr_iclr ? pwdata[IRQ_W-1:0] : '0;
		irq_stat_next           = (irq_stat_reg & ~irq_clr) | irq_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_reg      <= |(irq_stat_next & irq_en_reg);
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign shed_req       = shed_vec;
	assign shed_policy    = policy_reg;
	assign local_override = lo_vec;
	assign alert_out      = alert_reg;
	assign alert_taken    = alert_taken_reg;
	assign irq            = irq_reg;

endmodule : rssa_ctl

// file: testbench/rssa_monitor.sv
`timescale 1ns/10ps
module rssa_monitor
	import rssa_pkg::*;
#(
	parameter int NUM_OUT = 2 // Output blocks
)(
	input wire logic               pclk,           // Clock
	input wire logic               presetn,        // Async reset, low
	input wire logic               psel,           // APB select
	input wire logic               penable,        // APB enable
	input wire logic               pwrite,         // APB direction
	input wire logic [PADDR_W-1:0] paddr,          // APB address
	input wire logic [31:0]        prdata,         // APB read data
	input wire logic               pready,         // APB ready
	input wire logic [NUM_OUT-1:0] remote_output_mode_active,    // Remote-output mode
	input wire logic [NUM_OUT-1:0] block_oos,      // Out of service
	input wire logic [NUM_OUT-1:0] shed_req,       // Shed request
	input wire logic [NUM_OUT-1:0] local_override, // Safe state
	input wire logic               alert_taken,    // Report accepted
	input wire rssa_alert_t        alert_out       // Report strobe
);
	localparam logic [11:0] A_FLAG  = {2'b00, IDX_SAFE_FLAG, 2'b00};
	localparam logic [11:0] A_SET   = {2'b00, IDX_SAFE_SET, 2'b00};
	localparam logic [11:0] A_CLR   = {2'b00, IDX_SAFE_CLEAR, 2'b00};
	localparam logic [11:0] A_LIMIT = {2'b00, IDX_ALERT_LIMIT, 2'b00};
	wire rd_ans = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	property p_apb_wait;
		s_access |-> !pready ##1 pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer not after one wait");
	property p_flag_rd;
		rd_ans && paddr == A_FLAG |-> prdata == 32'h1 || prdata == 32'h2;
	endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("flag read bad code");
	property p_set_rd;
		rd_ans && paddr == A_SET |-> prdata == 32'h1;
	endproperty
	a_set_rd: assert property (p_set_rd) else $error("set command not read as off");
	property p_clr_rd;
		rd_ans && paddr == A_CLR |-> prdata == 32'h1;
	endproperty
	a_clr_rd: assert property (p_clr_rd) else $error("clear command not read as off");
	property p_limit_rd;
		rd_ans && paddr == A_LIMIT |-> prdata <= 32'h3;
	endproperty
	a_limit_rd: assert property (p_limit_rd) else $error("limit above maximum");
	property p_oos_keep;
		(local_override & ~$past(local_override) & $past(block_oos)) == '0;
	endproperty
	a_oos_keep: assert property (p_oos_keep) else $error("override on idle block");
	property p_shed_src;
		(shed_req & ~$past(remote_output_mode_active) & ~$past(remote_output_mode_active, 2)) == '0;
	endproperty
	a_shed_src: assert property (p_shed_src) else $error("shed without remote mode");
	property p_taken_new;
		alert_taken |-> alert_out.valid && !alert_out.resend ##1 !alert_taken;
	endproperty
	a_taken_new: assert property (p_taken_new) else $error("taken without fresh send");
	property p_resend_alone;
		alert_out.valid && alert_out.resend |-> !alert_taken;
	endproperty
	a_resend_alone: assert property (p_resend_alone) else $error("resend with take");
endmodule : rssa_monitor

bind rssa_ctl rssa_monitor #(.NUM_OUT(NUM_OUT)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .remote_output_mode_active(remote_output_mode_active),
	.block_oos(block_oos), .shed_req(shed_req), .local_override(local_override),
	.alert_taken(alert_taken), .alert_out(alert_out)
);

// file: testbench/rssa_host_model.sv
`timescale 1ns/10ps
module rssa_host_model
	import rssa_pkg::*;
(
	input  wire logic         pclk,               // Clock
	input  wire logic         presetn,            // Async reset, low
	input  wire logic         want,               // Keep reports coming
	input  wire logic         confirm_en,         // Confirm what arrives
	input  wire logic         alert_taken,        // Report accepted
	input  wire rssa_alert_t  alert_out,          // Report strobe
	output logic              alert_pending,      // Report waiting
	output logic              alert_confirm,      // Confirm pulse
	output logic [1:0]        alert_confirm_slot, // Slot confirmed
	output int                n_taken,            // Reports accepted
	output int                n_resend            // Resends seen
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_pending      <= 1'b0;
			alert_confirm      <= 1'b0;
			alert_confirm_slot <= 2'b00;
			n_taken            <= 0;
			n_resend           <= 0;
		end else begin
			// Drop at the take edge, or the same report goes twice
			alert_pending      <= want && !alert_taken;
			alert_confirm      <= confirm_en && alert_out.valid;
			alert_confirm_slot <= alert_out.slot;
			n_taken            <= n_taken + int'(alert_taken);
			n_resend           <= n_resend + int'(alert_out.valid && alert_out.resend);
		end
	end
endmodule : rssa_host_model

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb
	import rssa_pkg::*;
;
	logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]        paddr = '0;
	logic [31:0]        pwdata = '0, prdata, rd;
	logic               pready, pslverr, err, field_fault = 0, want = 0, confirm_en = 0;
	logic [1:0]         remote_output_mode_active = '0, remote_output_mode_write = '0, block_oos = '0;
	logic [1:0]         shed_req, local_override, slot;
	logic [7:0]         shed_policy;
	logic               alert_pending, alert_taken, alert_confirm, irq;
	rssa_alert_t        alert_out;
	int                 n_errors = 0, comparisons = 0, cycles = 0, n, n_taken, n_resend;
	always #4 pclk = ~pclk;
	rssa_ctl #(.NUM_OUT(2), .TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .remote_output_mode_active(remote_output_mode_active), .remote_output_mode_write(remote_output_mode_write),
		.block_oos(block_oos), .field_fault(field_fault), .shed_req(shed_req),
		.shed_policy(shed_policy), .local_override(local_override),
		.alert_pending(alert_pending), .alert_taken(alert_taken), .alert_out(alert_out),
		.alert_confirm(alert_confirm), .alert_confirm_slot(slot), .irq(irq));
	rssa_host_model host (.pclk(pclk), .presetn(presetn), .want(want), .confirm_en(confirm_en),
		.alert_taken(alert_taken), .alert_out(alert_out), .alert_pending(alert_pending),
		.alert_confirm(alert_confirm), .alert_confirm_slot(slot), .n_taken(n_taken),
		.n_resend(n_resend));
	task automatic give_verdict();
		$display("comparisons %0d, n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	// Holds the request until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask : wr
	task automatic chk_rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0000_0000);
		chk(nm, exp, rd);
	endtask : chk_rd
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk_rd("shed timeout", IDX_SHED_TIMEOUT, SHED_TIMEOUT_RST);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		chk_rd("set cmd", IDX_SAFE_SET, CMD_OFF);
		chk_rd("clear cmd", IDX_SAFE_CLEAR, CMD_OFF);
		chk_rd("max", IDX_ALERT_MAX, ALERT_MAX);
		chk_rd("limit", IDX_ALERT_LIMIT, ALERT_MAX);
		chk_rd("retry", IDX_RETRY, RETRY_RST);
		xfer(1'b0, 8'h3f, 32'h0000_0000);
		chk("unmapped err", 1'b1, err);
		wr(IDX_ALERT_MAX, 32'h0000_0005);
		chk_rd("max", IDX_ALERT_MAX, ALERT_MAX);
		wr(IDX_ALERT_LIMIT, 32'h0000_0004);
		chk_rd("limit", IDX_ALERT_LIMIT, ALERT_MAX);
		wr(IDX_RETRY, 32'h0000_0000);
		chk_rd("retry", IDX_RETRY, RETRY_RST);
		wr(IDX_SAFE_FLAG, FLAG_ACTIVE);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		block_oos <= 2'b10;
		wr(IDX_SAFE_SET, CMD_GO);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		wr(IDX_FEATURE, 32'h0000_0001 << FEAT_SAFE_BIT);
		wr(IDX_IRQ_ENABLE, 32'h0000_0001 << IRQ_SAFE_BIT);
		wr(IDX_SAFE_SET, CMD_OFF);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		wr(IDX_SAFE_SET, CMD_GO);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_ACTIVE);
		chk("override", 2'b01, local_override);
		chk("irq", 1'b1, irq);
		wr(IDX_IRQ_CLEAR, 32'h0000_0001 << IRQ_SAFE_BIT);
		repeat (2) @(posedge pclk);
		chk("irq", 1'b0, irq);
		field_fault <= 1'b1;
		wr(IDX_SAFE_CLEAR, CMD_OFF);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_ACTIVE);
		wr(IDX_SAFE_CLEAR, CMD_GO);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		chk("override", 2'b01, local_override);
		field_fault <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("override", 2'b00, local_override);
		wr(IDX_FEATURE, 32'h0000_0000);
		wr(IDX_SAFE_SET, CMD_GO);
		chk_rd("flag", IDX_SAFE_FLAG, FLAG_CLEAR);
		wr(IDX_SHED_POLICY, 32'h0000_0005);
		// Policy lands at the answer edge; look one edge later
		@(posedge pclk);
		chk("policy", 8'h05, shed_policy);
		wr(IDX_SHED_TIMEOUT, 32'h0000_0003);
		remote_output_mode_active <= 2'b01;
		// Writes every 8 clocks allow at most 2 ticks, below the timeout of 3
		for (int i = 0; i < 11; i++) begin
			remote_output_mode_write <= 2'b01;
			@(posedge pclk);
			remote_output_mode_write <= 2'b00;
			if (i < 10) repeat (7) @(posedge pclk);
		end
		chk("shed held", 2'b00, shed_req);
		n = 0;
		while (shed_req[0] !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("shed", 2'b01, shed_req);
		chk("shed time", 1'b1, n >= 8 && n <= 20);
		remote_output_mode_active <= 2'b00;
		repeat (3) @(posedge pclk);
		chk("shed drop", 2'b00, shed_req);
		chk_rd("irq status", IDX_IRQ_STATUS, 32'h0000_0001 << IRQ_SHED_BIT);
		wr(IDX_SHED_TIMEOUT, 32'h0000_0000);
		remote_output_mode_active <= 2'b11;
		repeat (60) @(posedge pclk);
		chk("shed zero", 2'b00, shed_req);
		remote_output_mode_active <= 2'b00;
		wr(IDX_RETRY, 32'h0000_0002);
		wr(IDX_ALERT_LIMIT, 32'h0000_0002);
		want <= 1'b1;
		repeat (60) @(posedge pclk);
		chk("taken", 32'd2, n_taken);
		chk("resent", 1'b1, n_resend > 0);
		wr(IDX_ALERT_LIMIT, 32'h0000_0000);
		confirm_en <= 1'b1;
		repeat (60) @(posedge pclk);
		chk("taken", 32'd2, n_taken);
		wr(IDX_ALERT_LIMIT, 32'h0000_0003);
		repeat (60) @(posedge pclk);
		chk("more taken", 1'b1, n_taken > 2);
		confirm_en <= 1'b0;
		repeat (60) @(posedge pclk);
		chk_rd("in flight", IDX_BLOCK_STATE, 32'(ALERT_MAX));
		give_verdict();
	end
endmodule : tb
